// ---- pvd_palette_dac.sv ----
// Summary of operation
// R1 - all inputs sampled on rising strobe edge, presented synchronously by controller
// R2 - channel write enables and pedestal shift active low, all other inputs active high
// R3 - codes complementary: 1111 is zero-scale brightest, 0000 full-scale black
// R4 - strobe is sole clock; codes and switches re-registered before converters
// R5 - four data bits form one word, first bit most significant
// R6 - four address bits select one of sixteen entries for write and read
// R7 - three separate 16x4 memories, each with own write enable
// R8 - all write enables high: read mode, addressed entry registered to outputs
// R9 - write enable low stores data word at address in that channel only
// R10 - during write, data passes uninverted to output latches unless overridden
// R11 - peak white forces all channels to 1111 when no blank or sync
// R12 - peak white loses to blanking and sync
// R13 - pedestal shift low enables offset switch on all channels, never overridden
// R14 - blanking forces 0000 and blank switch; beats white, loses to sync
// R15 - sync forces 0000, blank switch, and sync switch on green only
// R16 - sync has highest priority among composite commands
// R17 - red and blue never carry sync offset, only (shifted) blank level
// R18 - white, blank and pedestal shift act on all three channels together
// R19 - direct build option: three direct code inputs replace memory path
// R20 - no reset for memory and codes; undefined until written and strobed (reset_n here clears codes and switches to 0, memory stays unreset)
// R21 - each edge registers code plus blank, sync, shift switches per channel (here only edges that take a word from the buffer load new values; others hold)
`timescale 1ns/100ps
`include "pvd_map.svh"
module pvd_palette_dac import pvd_pkg::*; #(
    parameter bit DIRECT_CODES = 1'b0
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    // pixel stream from the controller
    input  wire logic       pixValid,
    output logic            pixReady,
    input  wire logic [3:0] paletteIndex,
    input  wire logic [3:0] paletteWdata,
    input  wire logic       writeGreen_n,
    input  wire logic       writeRed_n,
    input  wire logic       writeBlue_n,
    input  wire logic [3:0] greenDirectCode,
    input  wire logic [3:0] redDirectCode,
    input  wire logic [3:0] blueDirectCode,
    input  wire logic       peakWhite,
    input  wire logic       pedestalShift,
    input  wire logic       blanking,
    input  wire logic       syncCmd,
    // converter side
    input  wire logic       convReady,
    output logic [3:0]      greenCode,
    output logic [3:0]      redCode,
    output logic [3:0]      blueCode,
    output logic [2:0]      blankSwitch,
    output logic            syncSwitch,
    output logic [2:0]      shiftSwitch,
    output logic            convUpdate
);
    localparam int PIXW = 4 + 4 + 3 + 12 + 4;

    typedef struct packed {
        logic       updated;
        pvd_drive_s green;
        pvd_drive_s red;
        pvd_drive_s blue;
    } pvd_state_s;

    pvd_state_s       st;
    pvd_state_s       next_st;
    logic [PIXW-1:0]  pixIn;
    logic [PIXW-1:0]  pixOut;
    logic             fifoValid;
    logic             take;
    pvd_index_t       index;
    pvd_code_t        wdata;
    logic [2:0]       write_n;
    logic [11:0]      direct;
    pvd_comp_s        comp;
    pvd_code_t        memCode [`PVD_CH_N];
    pvd_code_t        chCode [`PVD_CH_N];

    // R1 synchronous input capture
    assign pixIn = {paletteIndex, paletteWdata, writeBlue_n, writeRed_n, writeGreen_n,
                    blueDirectCode, redDirectCode, greenDirectCode,
                    syncCmd, blanking, peakWhite, pedestalShift};

    pvd_fifo #(
        .WIDTH (PIXW),
        .DEPTH (`PVD_FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .reset_n  (reset_n),
        .inData   (pixIn),
        .inValid  (pixValid),
        .inReady  (pixReady),
        .outData  (pixOut),
        .outValid (fifoValid),
        .outReady (convReady)
    );

    assign take = fifoValid && convReady;

    // R5 first bit is msb
    // R6 index msb first
    assign index   = pixOut[PIXW-1 -: 4];
    assign wdata   = pixOut[PIXW-5 -: 4];
    // R2 write enables active low
    assign write_n = pixOut[PIXW-9 -: 3];
    assign direct  = pixOut[15:4];
    assign comp    = pvd_comp_s'(pixOut[3:0]);

    // R7 one memory per channel
    generate
        for (genvar ch = 0; ch < `PVD_CH_N; ch++) begin : g_chan
            // one private memory per channel, single writer each
            pvd_code_t palette [`PVD_DEPTH];
            // R9 store into this channel only
            always_ff @(posedge clk) begin
                if (take && !DIRECT_CODES && !write_n[ch]) begin
                    palette[index] <= wdata;
                end
            end
            // R8 read addressed entry
            // R10 write data passes uninverted
            assign memCode[ch] = write_n[ch] ? palette[index] : wdata;
            // R19 direct build option
            assign chCode[ch] = DIRECT_CODES ? direct[ch*4 +: 4] : memCode[ch];
        end
    endgenerate

    function automatic pvd_drive_s drive(input pvd_code_t code, input pvd_comp_s c, input logic isGreen);
        pvd_drive_s d;
        d = '0;
        d.code = code;
        // R11 peak white forces zero scale
        // R3 1111 is zero scale
        if (c.white) begin
            d.code = `PVD_ZERO_SCALE;
        end
        // R12 blank beats white
        // R14 blank forces full scale
        if (c.blank) begin
            d.code    = `PVD_FULL_SCALE;
            d.blankSw = 1'b1;
        end
        // R16 sync beats white and blank
        // R15 sync with blank switch
        // R17 sync offset green only
        if (c.sync) begin
            d.code    = `PVD_FULL_SCALE;
            d.blankSw = 1'b1;
            d.syncSw  = isGreen;
        end
        // R13 shift on low, never overridden
        d.shiftSw = !c.bright;
        return d;
    endfunction : drive

    // R18 all channels share the commands
    always_comb begin
        next_st = st;
        next_st.updated = take;
        if (take) begin
            next_st.green = drive(chCode[`PVD_CH_GREEN], comp, 1'b1);
            next_st.red   = drive(chCode[`PVD_CH_RED], comp, 1'b0);
            next_st.blue  = drive(chCode[`PVD_CH_BLUE], comp, 1'b0);
        end
    end

    // R4 re-register before converters
    // R21 code and switches together
    // R20 codes cleared by reset_n, then set on edges that take a word
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign greenCode   = st.green.code;
    assign redCode     = st.red.code;
    assign blueCode    = st.blue.code;
    assign blankSwitch = {st.blue.blankSw, st.red.blankSw, st.green.blankSw};
    assign syncSwitch  = st.green.syncSw;
    assign shiftSwitch = {st.blue.shiftSw, st.red.shiftSw, st.green.shiftSw};
    assign convUpdate  = st.updated;

    sync_green_a : assert property (@(posedge clk) disable iff (!reset_n) // R15
        (take && comp.sync) |=> (syncSwitch && greenCode == `PVD_FULL_SCALE && blankSwitch == 3'h7))
        else $error("sync did not drive green");
    sync_only_green_a : assert property (@(posedge clk) disable iff (!reset_n) // R17
        !st.red.syncSw && !st.blue.syncSw)
        else $error("sync offset on red or blue");
    white_force_a : assert property (@(posedge clk) disable iff (!reset_n) // R11
        (take && comp.white && !comp.blank && !comp.sync) |=>
        (greenCode == `PVD_ZERO_SCALE && redCode == `PVD_ZERO_SCALE && blueCode == `PVD_ZERO_SCALE))
        else $error("peak white not forced");
    white_loses_a : assert property (@(posedge clk) disable iff (!reset_n) // R12
        (take && comp.white && (comp.blank || comp.sync)) |=> (redCode == `PVD_FULL_SCALE))
        else $error("peak white won over blank");
    blank_force_a : assert property (@(posedge clk) disable iff (!reset_n) // R14
        (take && comp.blank && !comp.sync) |=> (blankSwitch == 3'h7 && !syncSwitch && blueCode == `PVD_FULL_SCALE))
        else $error("blank not forced");
    shift_all_a : assert property (@(posedge clk) disable iff (!reset_n) // R13
        take |=> (shiftSwitch == {3{!$past(comp.bright)}}))
        else $error("shift switch wrong");
    write_pass_a : assert property (@(posedge clk) disable iff (!reset_n) // R10
        (take && !DIRECT_CODES && !write_n[0] && comp == '0) |=> (greenCode == $past(wdata)))
        else $error("write data not passed");
    read_back_a : assert property (@(posedge clk) disable iff (!reset_n) // R9
        (take && !DIRECT_CODES && !write_n[1] && comp == '0)
        ##1 (take && write_n[1] && comp == '0 && index == $past(index))
        |=> (redCode == $past(wdata, 2)))
        else $error("written entry not read back");
    hold_a : assert property (@(posedge clk) disable iff (!reset_n) // R4
        !take |=> ($stable(greenCode) && $stable(redCode) && !convUpdate))
        else $error("codes changed without update");
endmodule : pvd_palette_dac

// ---- pvd_map.svh ----
`ifndef PVD_MAP_SVH
`define PVD_MAP_SVH

// code width and palette depth
`define PVD_CODE_W      4
`define PVD_INDEX_W     4
`define PVD_DEPTH       16
// composite forced codes
`define PVD_ZERO_SCALE  4'hF
`define PVD_FULL_SCALE  4'h0
// pixel stream buffer
`define PVD_FIFO_DEPTH  4
// channel order inside a 12-bit colour word
`define PVD_CH_GREEN    0
`define PVD_CH_RED      1
`define PVD_CH_BLUE     2
`define PVD_CH_N        3

`endif

// ---- pvd_pkg.sv ----
package pvd_pkg;
    typedef logic [3:0] pvd_code_t;
    typedef logic [3:0] pvd_index_t;

    // composite command carried with each pixel
    typedef struct packed {
        logic sync;
        logic blank;
        logic white;
        logic bright;
    } pvd_comp_s;

    // converter drive for one channel
    typedef struct packed {
        pvd_code_t code;
        logic      blankSw;
        logic      syncSw;
        logic      shiftSw;
    } pvd_drive_s;
endpackage : pvd_pkg

// ---- pvd_fifo.sv ----
`timescale 1ns/100ps
module pvd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0]   count;
    } pvdf_state_s;

    pvdf_state_s          st;
    pvdf_state_s          next_st;
    logic [WIDTH-1:0]     mem [DEPTH];
    logic                 push;
    logic                 pop;

    assign inReady  = (st.count != (AW+1)'(DEPTH));
    assign outValid = (st.count != '0);
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = mem[st.rdPtr];

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wrPtr = (st.wrPtr == AW'(DEPTH - 1)) ? '0 : st.wrPtr + AW'(1);
        end
        if (pop) begin
            next_st.rdPtr = (st.rdPtr == AW'(DEPTH - 1)) ? '0 : st.rdPtr + AW'(1);
        end
        unique case ({push, pop})
            2'b10: next_st.count = st.count + (AW+1)'(1);
            2'b01: next_st.count = st.count - (AW+1)'(1);
            2'b00, 2'b11: next_st.count = st.count;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[st.wrPtr] <= inData;
        end
    end

    fifo_bound_a : assert property (@(posedge clk) disable iff (!reset_n)
        st.count <= (AW+1)'(DEPTH))
        else $error("fifo count beyond depth");
    fifo_noover_a : assert property (@(posedge clk) disable iff (!reset_n)
        (st.count == (AW+1)'(DEPTH)) |-> !inReady)
        else $error("fifo ready while full");
endmodule : pvd_fifo

// ---- pvd_ctrl_model.sv ----
`timescale 1ns/100ps
module pvd_ctrl_model (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        push,
    input  wire logic [14:0] pushWord,
    input  wire logic        pixReady,
    output logic             pixValid,
    output logic [14:0]      word
);
    logic [14:0] pend[$];
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend.delete();
            pixValid <= 1'b0;
            word     <= 15'h7FFF;
        end else begin
            if (pixValid && pixReady)
                void'(pend.pop_front());
            if (push)
                pend.push_back(pushWord);
            // change after edge, hold until taken
            pixValid <= (pend.size() != 0);
            // idle lines toggle, inverting their previous value on every edge
            word <= (pend.size() != 0) ? pend[0] : ~word;
        end
    end
endmodule : pvd_ctrl_model

// ---- tb_palette_video_dac_control.sv ----
`timescale 1ns/100ps
`define CHK(what, exp, got) begin totalChecks++; if ((got) !== (exp)) begin errTotal++; \
    $display("CHECK FAILED %s exp %h got %h", what, exp, got); end end
module tb_palette_video_dac_control;
    logic        clk;
    logic        reset_n;
    logic        push;
    logic [14:0] pushWord;
    logic        pixValid;
    logic        pixReady;
    logic [14:0] word;
    logic        convReady;
    logic [3:0]  greenCode;
    logic [3:0]  redCode;
    logic [3:0]  blueCode;
    logic [2:0]  blankSwitch;
    logic        syncSwitch;
    logic [2:0]  shiftSwitch;
    logic        convUpdate;
    logic [18:0] seen;
    int          errTotal;
    int          totalChecks;
    int          pulses;
    // word: index, data, write_n g/r/b, white/shift/blank/sync; then codes g/r/b, switches
    logic [33:0] rows [0:12] = '{
        {4'h3, 4'hA, 3'h0, 4'h4, 12'hAAA, 7'h00}, {4'h3, 4'h5, 3'h3, 4'h4, 12'h5AA, 7'h00},
        {4'h3, 4'h3, 3'h5, 4'h4, 12'h53A, 7'h00}, {4'h3, 4'h0, 3'h7, 4'h4, 12'h53A, 7'h00},
        {4'h3, 4'h0, 3'h7, 4'hC, 12'hFFF, 7'h00}, {4'h3, 4'h0, 3'h7, 4'hE, 12'h000, 7'h70},
        {4'h3, 4'h0, 3'h7, 4'hB, 12'h000, 7'h7F}, {4'h3, 4'h0, 3'h7, 4'h0, 12'h53A, 7'h07},
        {4'hF, 4'h1, 3'h0, 4'h4, 12'h111, 7'h00}, {4'hF, 4'h9, 3'h3, 4'h6, 12'h000, 7'h70},
        {4'hF, 4'h0, 3'h7, 4'h4, 12'h911, 7'h00}, {4'h3, 4'h0, 3'h7, 4'h5, 12'h000, 7'h78},
        {4'h3, 4'h0, 3'h7, 4'h4, 12'h53A, 7'h00}};
    assign seen = {greenCode, redCode, blueCode, blankSwitch, syncSwitch, shiftSwitch};
    pvd_ctrl_model model (.clk(clk), .reset_n(reset_n), .push(push), .pushWord(pushWord),
        .pixReady(pixReady), .pixValid(pixValid), .word(word));
    pvd_palette_dac #(.DIRECT_CODES(1'b0)) uut (.clk(clk), .reset_n(reset_n),
        .pixValid(pixValid), .pixReady(pixReady), .paletteIndex(word[14:11]),
        .paletteWdata(word[10:7]), .writeGreen_n(word[6]), .writeRed_n(word[5]),
        .writeBlue_n(word[4]), .greenDirectCode(4'h0), .redDirectCode(4'h0),
        .blueDirectCode(4'h0), .peakWhite(word[3]), .pedestalShift(word[2]),
        .blanking(word[1]), .syncCmd(word[0]), .convReady(convReady),
        .greenCode(greenCode), .redCode(redCode), .blueCode(blueCode),
        .blankSwitch(blankSwitch), .syncSwitch(syncSwitch), .shiftSwitch(shiftSwitch),
        .convUpdate(convUpdate));
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : giveVerdict
    task automatic sendWord(input logic [14:0] w);
        @(posedge clk);
        push     <= 1'b1;
        pushWord <= w;
        @(posedge clk);
        push     <= 1'b0;
    endtask : sendWord
    task automatic awaitUpdate();
        int n;
        n = 0;
        @(negedge clk);
        while (convUpdate !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        `CHK("convUpdate", 1'b1, convUpdate)
    endtask : awaitUpdate
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        errTotal++;
        giveVerdict();
    end
    initial begin
        reset_n     = 1'b0;
        push        = 1'b0;
        pushWord    = 15'h0;
        convReady   = 1'b1;
        errTotal    = 0;
        totalChecks = 0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        `CHK("resetOut", 19'h0, seen)
        `CHK("resetReady", 1'b1, pixReady)
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            sendWord(rows[i][33:19]);
            awaitUpdate();
            `CHK("row", rows[i][18:0], seen)
        end
        $display("test table done");
        // stall the converter side until the buffer refuses
        @(posedge clk);
        convReady <= 1'b0;
        for (int i = 3; i < 9; i++)
            sendWord(rows[i + 2][33:19]);
        repeat (4) @(posedge clk);
        @(negedge clk);
        `CHK("fullReady", 1'b0, pixReady)
        `CHK("stallHold", rows[12][18:7], seen[18:7])
        @(posedge clk);
        convReady <= 1'b1;
        pulses = 0;
        repeat (20) begin
            @(negedge clk);
            pulses += (convUpdate === 1'b1);
        end
        `CHK("drainCount", 6, pulses)
        `CHK("drainLast", rows[10][18:0], seen)
        $display("test backpressure done");
        @(posedge clk);
        reset_n <= 1'b0;
        @(negedge clk);
        `CHK("midReset", 20'h0, {convUpdate, seen})
        @(posedge clk);
        reset_n <= 1'b1;
        sendWord(rows[12][33:19]);
        awaitUpdate();
        `CHK("paletteKept", rows[12][18:0], seen)
        $display("test mid reset done");
        giveVerdict();
    end
endmodule : tb_palette_video_dac_control
